//--- pmw_write_port.sv
/*
  Write side of a multiplexed address/data parallel memory port with an AHB-Lite register slave.
  Assumes one 125 MHz clock, inputs synchronous to it, and an external address latch.
*/
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "pmw_defs.svh"

module pmw_write_port (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             latch_out,
  output logic             write_n_out,
  output logic [15:0]      shared_addr_data_bus_out,
  output logic             shared_addr_data_bus_oe
);
  import pmw_pkg::*;

  pmw_state_type state_reg, state_next;
  logic [`PMW_CTRL_BITS-1:0] port_control_register;
  logic [15:0] addr_reg;
  logic [31:0] data_reg;
  logic        pend_reg;
  logic        pclk_reg;
  logic [5:0]  cnt_reg, cnt_next;
  logic [1:0]  idx_reg;
  logic [1:0]  grp_reg;
  logic        dp_valid_reg, dp_write_reg;
  logic [7:0]  dp_addr_reg;
  logic [31:0] hrdata_reg;

  // Register fields
  wire [4:0] strobe_duration_field = port_control_register[`PMW_DUR_MSB:`PMW_DUR_LSB];
  wire [1:0] word_packing_mode = port_control_register[`PMW_PACK_MSB:`PMW_PACK_LSB];
  wire       en    = port_control_register[`PMW_CTRL_EN];
  wire       hold  = port_control_register[`PMW_CTRL_HOLD];
  wire       slow  = port_control_register[`PMW_CTRL_SLOW];
  wire       wide  = port_control_register[`PMW_CTRL_WIDE];
  wire       pol_n = port_control_register[`PMW_CTRL_POL];
  wire       busy  = pend_reg || (state_reg != PMW_IDLE);

  // Bus decode
  wire addr_ph  = hsel && htrans[1] && hready;
  wire wr_ctrl  = dp_valid_reg && dp_write_reg && (dp_addr_reg == `PMW_OFS_CTRL);
  wire wr_addr  = dp_valid_reg && dp_write_reg && (dp_addr_reg == `PMW_OFS_ADDR);
  wire wr_data  = dp_valid_reg && dp_write_reg && (dp_addr_reg == `PMW_OFS_DATA);
  wire stall    = (wr_data || wr_addr) && busy;
  wire [31:0] rd_mux =
    (haddr == `PMW_OFS_CTRL) ? {20'h00000, port_control_register} :
    (haddr == `PMW_OFS_ADDR) ? {16'h0000, addr_reg} :
    (haddr == `PMW_OFS_DATA) ? data_reg :
    (haddr == `PMW_OFS_STAT) ? {31'h00000000, busy} : 32'h00000000;
  assign hreadyout = !stall;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  wire tick = ce && pclk_reg;

  wire [5:0] dur   = (strobe_duration_field == 5'h00) ? 6'h01 : {1'b0, strobe_duration_field};
  wire [5:0] low_l = (slow && dur > `PMW_SLOW_EXT) ? dur - `PMW_SLOW_EXT : (slow ? 6'h01 : dur);
  wire [5:0] sep_l = slow ? `PMW_SLOW_EXT + 6'h01 : 6'h01;
  wire [1:0] grp_last = !wide ? 2'h3 : ((word_packing_mode != 2'h0) ? 2'h0 : 2'h1);
  wire [1:0] word_last = wide ? 2'h1 : 2'h3;
  wire last_grp = (grp_reg == grp_last);
  wire last_word = (idx_reg == word_last);
  wire done_cnt = (cnt_reg == 6'h00);

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg - 6'h01;
    if (done_cnt)
    begin
      case (state_reg)
        PMW_IDLE:
        begin
          cnt_next = 6'h00;
          if (pend_reg)
          begin
            state_next = PMW_ALE;
            cnt_next   = `PMW_ALE_PCLK - 6'h01;
          end
        end
        PMW_ALE:
        begin
          state_next = PMW_ADH;
          cnt_next   = `PMW_ADH_PCLK - 6'h01;
        end
        PMW_ADH:
        begin
          state_next = PMW_GAP;
          cnt_next   = `PMW_GAP_PCLK - 6'h01;
        end
        PMW_GAP, PMW_SEP:
        begin
          state_next = PMW_STB;
          cnt_next   = low_l - 6'h01;
        end
        PMW_STB:
        begin
          state_next = hold ? PMW_HOLD : PMW_SEP;
          cnt_next   = hold ? 6'h00 : sep_l - 6'h01;
          if (!hold && (last_grp || last_word))
          begin
            state_next = last_word ? PMW_IDLE : PMW_ALE;
            cnt_next   = last_word ? 6'h00 : `PMW_ALE_PCLK - 6'h01;
          end
        end
        PMW_HOLD:
        begin
          state_next = PMW_SEP;
          cnt_next   = sep_l - 6'h01;
          if (last_grp || last_word)
          begin
            state_next = last_word ? PMW_IDLE : PMW_ALE;
            cnt_next   = last_word ? 6'h00 : `PMW_ALE_PCLK - 6'h01;
          end
        end
        default:
        begin
          state_next = PMW_IDLE;
          cnt_next   = 6'h00;
        end
      endcase
    end
  end

  wire strobe_end = tick && done_cnt && ((state_reg == PMW_HOLD) ||
                    (state_reg == PMW_STB && !hold));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= PMW_IDLE;
      cnt_reg   <= 6'h00;
      pclk_reg  <= 1'b0;
    end
    else if (ce)
    begin
      pclk_reg <= !pclk_reg;
      if (tick)
      begin
        state_reg <= state_next;
        cnt_reg   <= cnt_next;
      end
    end
  end

  // Strobe and group counters, address advance
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx_reg  <= 2'h0;
      grp_reg  <= 2'h0;
      addr_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (wr_addr && !busy)
        addr_reg <= hwdata[15:0];
      else if (strobe_end)
        addr_reg <= addr_reg + 16'h0001;
      if (strobe_end)
      begin
        idx_reg <= last_word ? 2'h0 : idx_reg + 2'h1;
        grp_reg <= (last_grp || last_word) ? 2'h0 : grp_reg + 2'h1;
      end
    end
  end

  // Register slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_reg          <= 1'b0;
      dp_write_reg          <= 1'b0;
      dp_addr_reg           <= 8'h00;
      hrdata_reg            <= 32'h00000000;
      port_control_register <= `PMW_CTRL_RST;
      data_reg              <= 32'h00000000;
      pend_reg              <= 1'b0;
    end
    else if (ce)
    begin
      if (!stall)
      begin
        dp_valid_reg <= addr_ph;
        dp_write_reg <= hwrite;
        dp_addr_reg  <= haddr;
        if (addr_ph && !hwrite)
          hrdata_reg <= rd_mux;
      end
      if (wr_ctrl)
        port_control_register <= hwdata[`PMW_CTRL_BITS-1:0];
      if (wr_data && !busy && en)
      begin
        data_reg <= hwdata;
        pend_reg <= 1'b1;
      end
      else if (tick && state_reg == PMW_IDLE && done_cnt)
        pend_reg <= 1'b0;
    end
  end

  // Pin decode
  wire ale_act = (state_reg == PMW_ALE);
  wire [7:0]  byte_sel = data_reg[{idx_reg, 3'h0} +: 8];
  wire [15:0] half_sel = idx_reg[0] ? data_reg[31:16] : data_reg[15:0];
  wire addr_phase = ale_act || (state_reg == PMW_ADH);
  // upper address with data byte, full width data
  wire [15:0] wdata = wide ? half_sel : {addr_reg[15:8], byte_sel};
  assign latch_out   = ale_act ^ pol_n;
  assign write_n_out = !(state_reg == PMW_STB);
  assign shared_addr_data_bus_out = addr_phase ? addr_reg : wdata;
  assign shared_addr_data_bus_oe  = (state_reg != PMW_IDLE);

  // Check helpers
  logic [7:0] low_cnt, high_cnt;
  logic [2:0] grp_cnt;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_cnt  <= 8'h00;
      high_cnt <= 8'h00;
      grp_cnt  <= 3'h0;
    end
    else
    begin
      low_cnt  <= write_n_out ? 8'h00 : low_cnt + 8'h01;
      high_cnt <= (write_n_out && !ale_act) ? high_cnt + 8'h01 : 8'h00;
      if (ale_act)
        grp_cnt <= 3'h0;
      else if (!write_n_out && $past(write_n_out))
        grp_cnt <= grp_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_release;
    $fell(ale_act);
  endsequence
  sequence s_rise;
    $rose(write_n_out);
  endsequence
  sequence s_group_end;
    ($rose(ale_act) && $past(shared_addr_data_bus_oe)) || $fell(shared_addr_data_bus_oe);
  endsequence

  property p_group8;
    s_group_end ##0 !wide |-> grp_cnt == `PMW_BYTES_GROUP;
  endproperty
  a_group8: assert property (p_group8) else $error("byte group not four");
  property p_pack;
    s_group_end ##0 (wide && word_packing_mode != 2'h0) |-> grp_cnt == 3'h1;
  endproperty
  a_pack: assert property (p_pack) else $error("packed group over one");
  property p_pol;
    state_reg == PMW_IDLE |-> latch_out == pol_n;
  endproperty
  a_pol: assert property (p_pol) else $error("latch idle level wrong");
  property p_width;
    s_rise |-> ce == 1'b0 || $past(low_cnt) == {1'b0, low_l, 1'b0} - 8'h01;
  endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
  property p_tick;
    tick |=> !tick;
  endproperty
  a_tick: assert property (p_tick) else $error("port clock not half rate");
  property p_hold;
    s_rise ##0 hold |-> shared_addr_data_bus_oe [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("hold cycle dropped");
  property p_ale_wr;
    s_release |-> write_n_out [*4];
  endproperty
  a_ale_wr: assert property (p_ale_wr) else $error("strobe too soon");
  property p_addr_hold;
    s_release |-> (shared_addr_data_bus_out == addr_reg) [*2];
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address not held");
  property p_gap;
    $fell(write_n_out) && grp_cnt != 3'h0 && ce |->
      $past(high_cnt) >= {1'b0, sep_l, 1'b0} + (hold ? 8'h02 : 8'h00) - 8'h01;
  endproperty
  a_gap: assert property (p_gap) else $error("strobe gap short");
  property p_last_hold;
    s_rise ##0 hold |-> !ale_act [*2];
  endproperty
  a_last_hold: assert property (p_last_hold) else $error("latch during hold");
  property p_wide;
    !write_n_out |-> shared_addr_data_bus_oe && shared_addr_data_bus_out == wdata;
  endproperty
  a_wide: assert property (p_wide) else $error("data not driven");
endmodule // pmw_write_port

//--- pmw_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the parallel memory write port.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH
`define PMW_OFS_CTRL      8'h00
`define PMW_OFS_ADDR      8'h04
`define PMW_OFS_DATA      8'h08
`define PMW_OFS_STAT      8'h0c
`define PMW_CTRL_EN       0
`define PMW_DUR_LSB       1
`define PMW_DUR_MSB       5
`define PMW_CTRL_HOLD     6
`define PMW_CTRL_SLOW     7
`define PMW_CTRL_WIDE     8
`define PMW_PACK_LSB      9
`define PMW_PACK_MSB      10
`define PMW_CTRL_POL      11
`define PMW_CTRL_BITS     12
`define PMW_CTRL_RST      12'h000
`define PMW_TPCLK_NS      16
`define PMW_TCORE_NS      8
`define PMW_PCLK_DIV      (`PMW_TPCLK_NS / `PMW_TCORE_NS)
`define PMW_ALE_PCLK      6'h02
`define PMW_ADH_PCLK      6'h01
`define PMW_GAP_PCLK      6'h01
`define PMW_SLOW_EXT      6'h07
`define PMW_SLOW_MIN_DUR  6'h09
`define PMW_BYTES_GROUP   3'h4
`endif

//--- pmw_pkg.sv
/*
  Types of the parallel memory write port.
  Assumes pmw_defs.svh is reachable by bare name.
*/
`include "pmw_defs.svh"
package pmw_pkg;
  typedef enum logic [2:0] {
    PMW_IDLE = 3'h0,
    PMW_ALE  = 3'h1,
    PMW_ADH  = 3'h2,
    PMW_GAP  = 3'h3,
    PMW_STB  = 3'h4,
    PMW_HOLD = 3'h5,
    PMW_SEP  = 3'h6
  } pmw_state_type;
endpackage

//--- pmw_mem_model.sv
/*
  Behavioural asynchronous memory with an outside address latch.
  Assumes the bench resolves the bus level and drives pol to match the latch polarity.
*/
`timescale 1ns/1ns
module pmw_mem_model (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        pol,
  input wire logic        latch_out,
  input wire logic        write_n_out,
  input wire logic [15:0] bus
);
  logic        act_q;
  logic        wn_q;
  logic [15:0] addr_q;
  logic [15:0] dat_q;
  int          cnt;
  int          n_lat;
  int          n_stb;
  logic [15:0] s_addr [16];
  logic [15:0] s_data [16];
  int          s_low [16];
  int          s_pre [16];
  wire         act = latch_out ^ pol;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_q <= 1'b0;
      wn_q  <= 1'b1;
      cnt   <= 0;
      n_lat <= 0;
      n_stb <= 0;
    end
    else
    begin
      act_q <= act;
      wn_q  <= write_n_out;
      cnt   <= cnt + 1;
      if (act_q && !act)
      begin
        addr_q <= bus;
        n_lat  <= n_lat + 1;
        cnt    <= 1;
      end
      if (!write_n_out)
        dat_q <= bus;
      if (wn_q && !write_n_out)
      begin
        s_pre[n_stb] <= cnt;
        cnt          <= 1;
      end
      if (!wn_q && write_n_out)
      begin
        s_low[n_stb]  <= cnt;
        s_addr[n_stb] <= addr_q;
        s_data[n_stb] <= dat_q;
        n_stb         <= n_stb + 1;
        cnt           <= 1;
      end
    end
  end
endmodule // pmw_mem_model

//--- pmw_write_port_test.sv
/*
  Self-checking bench of the parallel memory write port over AHB-Lite.
  Assumes pmw_defs.svh by bare name and the memory model beside it.
*/
`timescale 1ns/1ns
`include "pmw_defs.svh"
module pmw_write_port_test;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic        hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hreadyout;
  logic        hresp;
  logic        latch_out;
  logic        write_n_out;
  logic        oe;
  logic        pol;
  logic [15:0] bus_out;
  logic [15:0] last_q = 16'h0000;
  wire  [15:0] bus = oe ? bus_out : ~last_q;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #4 hclk = ~hclk;
  always @(posedge hclk)
  begin
    if (oe)
      last_q <= bus_out;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end
  pmw_write_port DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .latch_out(latch_out),
    .write_n_out(write_n_out), .shared_addr_data_bus_out(bus_out),
    .shared_addr_data_bus_oe(oe));
  pmw_mem_model pm (.hclk(hclk), .hresetn(hresetn), .pol(pol), .latch_out(latch_out),
    .write_n_out(write_n_out), .bus(bus));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic run(input logic [11:0] c, input logic [15:0] a, input logic [31:0] d,
                     input int n);
    int          b;
    int          bl;
    int          k;
    int          lo;
    int          pre;
    logic [15:0] cur;
    xfer(1'b1, `PMW_OFS_CTRL, {20'h0, c});
    pol <= c[`PMW_CTRL_POL];
    xfer(1'b0, `PMW_OFS_CTRL, 32'h0);
    check(r, {20'h0, c});
    check({31'h0, hresp}, 32'h0);
    b  = pm.n_stb;
    bl = pm.n_lat;
    xfer(1'b1, `PMW_OFS_ADDR, {16'h0, a});
    xfer(1'b1, `PMW_OFS_DATA, d);
    repeat (4) @(posedge hclk);
    for (k = 0; k < 200; k++)
    begin
      xfer(1'b0, `PMW_OFS_STAT, 32'h0);
      if (r[0] === 1'b0)
        break;
    end
    check(32'(pm.n_stb - b), 32'(n));
    check(32'(pm.n_lat - bl), (c[8] && c[10:9] != 2'h0) ? 32'(n) : 32'(n > 0));
    lo = c[7] ? c[5:1] - 7 : c[5:1];
    for (k = 0; k < n; k++)
    begin
      cur = a + 16'(k);
      pre = (k == 0 || c[10:9] != 2'h0) ? 4 : 2 * ((c[7] ? 7 : 0) + c[6] + 1);
      check({16'h0, pm.s_data[b + k]},
            c[8] ? {16'h0, d[16 * k +: 16]} : {16'h0, cur[15:8], d[8 * k +: 8]});
      check({16'h0, pm.s_addr[b + k]},
            {16'h0, (c[8] && c[10:9] != 2'h0) ? cur : a});
      check(32'(pm.s_low[b + k]), 32'(2 * lo));
      check(32'(pm.s_pre[b + k]), 32'(pre));
    end
    check({31'h0, write_n_out}, 32'h1);
    check({31'h0, oe}, 32'h0);
    check({31'h0, latch_out}, {31'h0, c[`PMW_CTRL_POL]});
  endtask
  initial
  begin
    hresetn = 1'b0;
    ce      = 1'b1;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    haddr   = 8'h00;
    htrans  = 2'h0;
    hwdata  = 32'h0;
    pol     = 1'b0;
    repeat (10) @(posedge hclk);
    check({31'h0, latch_out}, 32'h0);
    check({31'h0, write_n_out}, 32'h1);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, `PMW_OFS_CTRL, 32'h0);
    check(r, 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    check(r, 32'h0);
    run(12'h007, 16'h1230, 32'h44332211, 4);
    run(12'h0d5, 16'h20fe, 32'hc3b2a190, 4);
    run(12'h1d3, 16'h0040, 32'hbeef5a5a, 2);
    run(12'hb3f, 16'hfffe, 32'h87654321, 2);
    run(12'h503, 16'h7fff, 32'h0badf00d, 2);
    run(12'h000, 16'h0100, 32'h11111111, 0);
    ce <= 1'b0;
    xfer(1'b1, `PMW_OFS_CTRL, 32'h00000800);
    ce <= 1'b1;
    xfer(1'b0, `PMW_OFS_CTRL, 32'h0);
    check(r, 32'h0);
    close_out();
  end
endmodule // pmw_write_port_test
